// *** rtl/usc_pkg.sv ***
// Shared constants and state types of the serial port control logic.
// Assumes one system clock and an oversampling tick from a baud timer.
package usc_pkg;

   // Special-function register map, page and reset value.
   localparam logic [7:0] USC_CTRL_ADDR  = 8'h98;
   localparam logic [7:0] USC_DATA_ADDR  = 8'h99;
   localparam logic [3:0] USC_PAGE       = 4'h0;
   localparam logic [7:0] USC_CTRL_RESET = 8'h40;
   localparam logic [7:0] USC_BIT_BASE   = 8'h98;

   // Field positions inside serial_port_control.
   localparam int USC_MODE_POS   = 7;
   localparam int USC_FIXED_POS  = 6;
   localparam int USC_FILTER_POS = 5;
   localparam int USC_REN_POS    = 4;
   localparam int USC_TB8_POS    = 3;
   localparam int USC_RB8_POS    = 2;
   localparam int USC_TXD_POS    = 1;
   localparam int USC_RXD_POS    = 0;

   // Frame timing: ticks per bit and index of the last data bit.
   localparam int         USC_OVS       = 16;
   localparam logic [2:0] USC_LAST_DATA = 3'h7;

   typedef enum logic [2:0] {
      TX_IDLE  = 3'b000,
      TX_START = 3'b001,
      TX_DATA  = 3'b010,
      TX_NINTH = 3'b011,
      TX_STOP  = 3'b100
   } usc_tx_state_type;

   typedef enum logic [2:0] {
      RX_IDLE  = 3'b000,
      RX_START = 3'b001,
      RX_DATA  = 3'b010,
      RX_NINTH = 3'b011,
      RX_STOP  = 3'b100
   } usc_rx_state_type;

endpackage : usc_pkg

// *** rtl/usc_rx.sv ***
// Receive frame engine: start detection, bit sampling and frame report.
// Assumes the line input is already synchronised to the clock.
`timescale 1ns/1ps
`default_nettype none
module usc_rx #(
   parameter int OVS = usc_pkg::USC_OVS
) (
   input  wire logic       clk,
   input  wire logic       rst,
   input  wire logic       line,
   input  wire logic       tick,
   input  wire logic       enable,
   input  wire logic       nine_bit,
   output logic            frame_valid,
   output logic [7:0]      frame_data,
   output logic            frame_ninth,
   output logic            frame_stop
);
   import usc_pkg::*;

   localparam int OSW = $clog2(OVS);

   usc_rx_state_type state;
   usc_rx_state_type next_state;
   logic [OSW-1:0]   os;
   logic [OSW-1:0]   next_os;
   logic [2:0]       cnt;
   logic [2:0]       next_cnt;
   logic [7:0]       next_frame_data;
   logic             next_frame_ninth;
   logic             next_frame_stop;
   logic             next_frame_valid;
   logic             half_end;
   logic             bit_end;
   logic             last_line;

   assign half_end = tick && (os == OSW'(OVS / 2 - 1));
   assign bit_end  = tick && (os == OSW'(OVS - 1));

   // Walks a frame; leaving the enable low drops any frame in progress.
   always_comb begin
      next_state       = state;
      next_cnt         = cnt;
      next_frame_data  = frame_data;
      next_frame_ninth = frame_ninth;
      next_frame_stop  = frame_stop;
      next_frame_valid = 1'h0;
      next_os          = os;
      if (tick) begin
         next_os = (bit_end || (state == RX_START && half_end)) ? '0 : OSW'(os + 1'h1);
      end
      case (state)
         RX_IDLE: begin
            next_os = '0;
            // A start is a high-to-low edge, so a low stop bit cannot restart a frame.
            if (enable && last_line && !line) begin
               next_state = RX_START;
            end
         end
         RX_START: begin
            if (half_end) begin
               next_state = line ? RX_IDLE : RX_DATA;
               next_cnt   = 3'h0;
            end
         end
         RX_DATA: begin
            if (bit_end) begin
               next_frame_data = {line, frame_data[7:1]};
               next_cnt        = 3'(cnt + 3'h1);
               if (cnt == USC_LAST_DATA) begin
                  next_state = nine_bit ? RX_NINTH : RX_STOP;
               end
            end
         end
         RX_NINTH: begin
            if (bit_end) begin
               next_frame_ninth = line;
               next_state       = RX_STOP;
            end
         end
         RX_STOP: begin
            if (bit_end) begin
               next_frame_stop  = line;
               next_frame_valid = 1'h1;
               next_state       = RX_IDLE;
            end
         end
         default: begin
            next_state = RX_IDLE;
         end
      endcase
      if (!enable) begin
         next_state       = RX_IDLE;
         next_frame_valid = 1'h0;
      end
   end

   // Registers the receive state and the reported frame.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         state       <= RX_IDLE;
         os          <= '0;
         cnt         <= 3'h0;
         frame_data  <= 8'h00;
         frame_ninth <= 1'h0;
         frame_stop  <= 1'h0;
         frame_valid <= 1'h0;
         last_line   <= 1'h1; // Idle line level, so no false edge follows reset.
      end else begin
         state       <= next_state;
         os          <= next_os;
         cnt         <= next_cnt;
         frame_data  <= next_frame_data;
         frame_ninth <= next_frame_ninth;
         frame_stop  <= next_frame_stop;
         frame_valid <= next_frame_valid;
         last_line   <= line;
      end
   end

   a_rx_disabled_quiet: assert property (@(posedge clk) disable iff (rst)
      !enable |=> !frame_valid)
      else $error("Frame reported while reception disabled.");

   a_rx_frame_length: assert property (@(posedge clk) disable iff (rst)
      (state == RX_STOP && next_state == RX_IDLE && enable) |=> frame_valid)
      else $error("Stop sample did not report a frame.");

endmodule : usc_rx
`default_nettype wire

// *** rtl/usc_top.sv ***
// Serial port control: control register, transmitter and receive filter.
// Assumes a CPU special-function bus on MCLK and an oversampling tick.
`timescale 1ns/1ps
`default_nettype none
module usc_top #(
   parameter int OVS = usc_pkg::USC_OVS
) (
   input  wire logic       MCLK,
   input  wire logic       RST,
   input  wire logic [3:0] SFR_PAGE,
   input  wire logic [7:0] SFR_ADDR,
   input  wire logic       SFR_WR,
   input  wire logic [7:0] SFR_WDATA,
   input  wire logic       SFR_RD,
   output logic [7:0]      SFR_RDATA,
   input  wire logic       BIT_WR,
   input  wire logic [7:0] BIT_ADDR,
   input  wire logic       BIT_VAL,
   input  wire logic       SAMPLE_TICK,
   input  wire logic       INT_ENABLE,
   output logic            INT_REQ,
   output logic            TX_PIN,
   input  wire logic       RX_PIN
);
   import usc_pkg::*;

   localparam int OSW = $clog2(OVS);

   // True when the byte access targets the given address on our page.
   function automatic logic sfr_hit(input logic [3:0] page, input logic [7:0] addr,
                                    input logic [7:0] target);
      sfr_hit = (page == USC_PAGE) && (addr == target);
   endfunction : sfr_hit

   logic             mode, filter, ren, tb8, rb8, txd, rxd;
   logic             next_mode, next_filter, next_ren, next_tb8, next_rb8, next_txd, next_rxd;
   logic [7:0]       rx_buf;
   logic [7:0]       next_rx_buf;
   logic [7:0]       next_rdata;
   logic             next_int_req;
   logic [7:0]       sw_we;
   logic [7:0]       sw_val;
   logic [7:0]       ctrl_view;
   logic             accept;
   logic             rx_meta, rx_sync;
   logic             rx_valid, rx_ninth, rx_stop;
   logic [7:0]       rx_data;
   usc_tx_state_type tx_state;
   usc_tx_state_type next_tx_state;
   logic [OSW-1:0]   tx_os;
   logic [OSW-1:0]   next_tx_os;
   logic [2:0]       tx_cnt;
   logic [2:0]       next_tx_cnt;
   logic [7:0]       tx_shift;
   logic [7:0]       next_tx_shift;
   logic             next_tx_pin;
   logic             tx_set;
   logic             tx_bit_end;
   logic             start_tx;

   // Software write lanes: a byte write or a single bit-addressed write.
   always_comb begin
      sw_we  = 8'h00;
      sw_val = 8'h00;
      if (SFR_WR && sfr_hit(SFR_PAGE, SFR_ADDR, USC_CTRL_ADDR)) begin
         sw_we  = 8'hFF;
         sw_val = SFR_WDATA;
      end else if (BIT_WR && BIT_ADDR[7:3] == USC_BIT_BASE[7:3]) begin
         sw_we  = 8'h01 << BIT_ADDR[2:0];
         sw_val = {8{BIT_VAL}};
      end
   end

   assign ctrl_view = {mode, 1'h1, filter, ren, tb8, rb8, txd, rxd};

   // A frame is kept only when the flag is clear and the filter passes.
   assign accept = rx_valid && !rxd &&
                   (!filter || (mode ? rx_ninth : rx_stop));

   // Control register update; hardware sets win over software clears.
   always_comb begin
      next_mode   = sw_we[USC_MODE_POS]   ? sw_val[USC_MODE_POS]   : mode;
      next_filter = sw_we[USC_FILTER_POS] ? sw_val[USC_FILTER_POS] : filter;
      next_ren    = sw_we[USC_REN_POS]    ? sw_val[USC_REN_POS]    : ren;
      next_tb8    = sw_we[USC_TB8_POS]    ? sw_val[USC_TB8_POS]    : tb8;
      next_rb8    = sw_we[USC_RB8_POS]    ? sw_val[USC_RB8_POS]    : rb8;
      next_txd    = (sw_we[USC_TXD_POS] ? sw_val[USC_TXD_POS] : txd) | tx_set;
      next_rxd    = (sw_we[USC_RXD_POS] ? sw_val[USC_RXD_POS] : rxd) | accept;
      next_rx_buf = rx_buf;
      if (accept) begin
         next_rx_buf = rx_data;
         next_rb8    = mode ? rx_ninth : rx_stop;
      end
      next_int_req = INT_ENABLE && (next_txd || next_rxd);
      next_rdata   = SFR_RDATA;
      if (SFR_RD) begin
         if (sfr_hit(SFR_PAGE, SFR_ADDR, USC_CTRL_ADDR)) begin
            next_rdata = ctrl_view;
         end else if (sfr_hit(SFR_PAGE, SFR_ADDR, USC_DATA_ADDR)) begin
            next_rdata = rx_buf;
         end else begin
            next_rdata = 8'h00;
         end
      end
   end

   // Registers the control bits, receive latch, read data and interrupt.
   always_ff @(posedge MCLK or posedge RST) begin
      if (RST) begin
         mode      <= USC_CTRL_RESET[USC_MODE_POS];
         filter    <= USC_CTRL_RESET[USC_FILTER_POS];
         ren       <= USC_CTRL_RESET[USC_REN_POS];
         tb8       <= USC_CTRL_RESET[USC_TB8_POS];
         rb8       <= USC_CTRL_RESET[USC_RB8_POS];
         txd       <= USC_CTRL_RESET[USC_TXD_POS];
         rxd       <= USC_CTRL_RESET[USC_RXD_POS];
         rx_buf    <= 8'h00;
         SFR_RDATA <= 8'h00;
         INT_REQ   <= 1'h0;
      end else begin
         mode      <= next_mode;
         filter    <= next_filter;
         ren       <= next_ren;
         tb8       <= next_tb8;
         rb8       <= next_rb8;
         txd       <= next_txd;
         rxd       <= next_rxd;
         rx_buf    <= next_rx_buf;
         SFR_RDATA <= next_rdata;
         INT_REQ   <= next_int_req;
      end
   end

   // Two-stage synchroniser on the receive line.
   always_ff @(posedge MCLK or posedge RST) begin
      if (RST) begin
         rx_meta <= 1'h1;
         rx_sync <= 1'h1;
      end else begin
         rx_meta <= RX_PIN;
         rx_sync <= rx_meta;
      end
   end

   usc_rx #(.OVS(OVS)) u_rx (
      .clk         (MCLK),
      .rst         (RST),
      .line        (rx_sync),
      .tick        (SAMPLE_TICK),
      .enable      (ren),
      .nine_bit    (mode),
      .frame_valid (rx_valid),
      .frame_data  (rx_data),
      .frame_ninth (rx_ninth),
      .frame_stop  (rx_stop)
   );

   // A data buffer write while a frame is on the line is ignored.
   assign start_tx   = SFR_WR && sfr_hit(SFR_PAGE, SFR_ADDR, USC_DATA_ADDR) &&
                       (tx_state == TX_IDLE);
   assign tx_bit_end = SAMPLE_TICK && (tx_os == OSW'(OVS - 1));

   // Transmit sequencer and the registered line level for the next state.
   always_comb begin
      next_tx_state = tx_state;
      next_tx_cnt   = tx_cnt;
      next_tx_shift = tx_shift;
      tx_set        = 1'h0;
      next_tx_os    = tx_os;
      if (SAMPLE_TICK) begin
         next_tx_os = tx_bit_end ? '0 : OSW'(tx_os + 1'h1);
      end
      case (tx_state)
         TX_IDLE: begin
            next_tx_os = '0;
            if (start_tx) begin
               next_tx_state = TX_START;
               next_tx_shift = SFR_WDATA;
            end
         end
         TX_START: begin
            if (tx_bit_end) begin
               next_tx_state = TX_DATA;
               next_tx_cnt   = 3'h0;
            end
         end
         TX_DATA: begin
            if (tx_bit_end) begin
               next_tx_shift = {1'h0, tx_shift[7:1]};
               next_tx_cnt   = 3'(tx_cnt + 3'h1);
               if (tx_cnt == USC_LAST_DATA) begin
                  next_tx_state = mode ? TX_NINTH : TX_STOP;
                  tx_set        = !mode;
               end
            end
         end
         TX_NINTH: begin
            if (tx_bit_end) begin
               next_tx_state = TX_STOP;
               tx_set        = 1'h1;
            end
         end
         TX_STOP: begin
            if (tx_bit_end) begin
               next_tx_state = TX_IDLE;
            end
         end
         default: begin
            next_tx_state = TX_IDLE;
         end
      endcase
      case (next_tx_state)
         TX_START: next_tx_pin = 1'h0;
         TX_DATA:  next_tx_pin = next_tx_shift[0];
         TX_NINTH: next_tx_pin = tb8;
         default:  next_tx_pin = 1'h1;
      endcase
   end

   // Registers the transmit state and the line.
   always_ff @(posedge MCLK or posedge RST) begin
      if (RST) begin
         tx_state <= TX_IDLE;
         tx_os    <= '0;
         tx_cnt   <= 3'h0;
         tx_shift <= 8'h00;
         TX_PIN   <= 1'h1;
      end else begin
         tx_state <= next_tx_state;
         tx_os    <= next_tx_os;
         tx_cnt   <= next_tx_cnt;
         tx_shift <= next_tx_shift;
         TX_PIN   <= next_tx_pin;
      end
   end

   default clocking cb @(posedge MCLK); endclocking
   default disable iff (RST);

   sequence s_tx_launch;
      start_tx ##1 (tx_state == TX_START && !TX_PIN);
   endsequence

   a_tx_launch_line: assert property (start_tx |-> s_tx_launch)
      else $error("Data buffer write did not start a frame.");

   a_fixed_bit_one: assert property (SFR_RD && sfr_hit(SFR_PAGE, SFR_ADDR, USC_CTRL_ADDR)
      |=> SFR_RDATA[USC_FIXED_POS])
      else $error("Control read returned zero in the fixed bit.");

   a_tx_done_sticky: assert property (txd && !(sw_we[USC_TXD_POS] && !sw_val[USC_TXD_POS])
      |=> txd)
      else $error("Transmit done cleared without software.");

   a_rx_done_sticky: assert property (rxd && !(sw_we[USC_RXD_POS] && !sw_val[USC_RXD_POS])
      |=> rxd)
      else $error("Receive done cleared without software.");

   a_tx_done_stop: assert property ((tx_state == TX_STOP && $past(tx_state) != TX_STOP)
      |-> txd)
      else $error("Transmit done missing at stop bit.");

   a_filter_eight: assert property ((rx_valid && !mode && filter && !rx_stop && !rxd
      && !sw_we[USC_RXD_POS]) |=> !rxd)
      else $error("Bad stop bit accepted with filter on.");

   a_filter_nine: assert property ((rx_valid && mode && filter && !rx_ninth && !rxd
      && !sw_we[USC_RXD_POS]) |=> !rxd)
      else $error("Data frame accepted with address filter on.");

   a_ninth_source: assert property ((accept && !sw_we[USC_RB8_POS])
      |=> rb8 == ($past(mode) ? $past(rx_ninth) : $past(rx_stop)) && rx_buf == $past(rx_data))
      else $error("Ninth bit field loaded from wrong source.");

   a_overrun_hold: assert property ((rx_valid && rxd) |=> rx_buf == $past(rx_buf))
      else $error("Receive latch overwritten while flag set.");

   a_irq_request: assert property (INT_ENABLE && (txd || rxd) && !sw_we[USC_TXD_POS]
      && !sw_we[USC_RXD_POS] |=> INT_REQ)
      else $error("Interrupt missing with a flag set.");

endmodule : usc_top
`default_nettype wire

// *** dv/usc_remote.sv ***
// Remote serial transceiver model facing the port's line pins.
// Assumes it shares the port's clock and oversampling tick.
`timescale 1ns/1ps
`default_nettype none
module usc_remote #(
   parameter int OVS = 4
) (
   input  wire logic clk,
   input  wire logic tick,
   input  wire logic nine,
   input  wire logic line_in,
   output logic      line_out
);
   logic [9:0] got;
   int         frames;

   // Waits for a number of oversampling ticks.
   task automatic ticks(input int n);
      repeat (n) begin
         @(posedge clk);
         while (tick !== 1'b1) @(posedge clk);
      end
   endtask : ticks

   // Sends start, data LSB first, then b and a high bit (stop or idle).
   task automatic send(input logic [7:0] d, input logic b);
      logic [10:0] f;
      f = {1'b1, b, d, 1'b0};
      for (int i = 0; i < 11; i++) begin
         line_out = f[i];
         ticks(OVS);
         #1;
      end
   endtask : send

   // Samples each frame from the port mid-bit and counts it.
   initial begin
      line_out = 1'b1;
      frames = 0;
      forever begin
         @(negedge line_in);
         ticks(OVS / 2);
         for (int i = 0; i < (nine ? 10 : 9); i++) begin
            ticks(OVS);
            got[i] = line_in;
         end
         frames++;
      end
   end
endmodule : usc_remote
`default_nettype wire

// *** dv/tb_uart_serial_control.sv ***
// Self-checking bench for the serial port control block.
// Assumes the remote transceiver model sits on the line pins.
`timescale 1ns/1ps
`default_nettype none
module tb_uart_serial_control;
   import usc_pkg::*;
   logic        MCLK = 1'b0;
   logic        RST = 1'b1;
   logic [3:0]  SFR_PAGE = 4'h0;
   logic [7:0]  SFR_ADDR = 8'h00;
   logic        SFR_WR = 1'b0;
   logic [7:0]  SFR_WDATA = 8'h00;
   logic        SFR_RD = 1'b0;
   logic [7:0]  SFR_RDATA;
   logic        BIT_WR = 1'b0;
   logic [7:0]  BIT_ADDR = 8'h00;
   logic        BIT_VAL = 1'b0;
   logic        SAMPLE_TICK = 1'b0;
   logic        INT_ENABLE = 1'b0;
   logic        INT_REQ;
   logic        TX_PIN;
   logic        RX_PIN;
   logic        nine = 1'b0;
   logic [7:0]  last = 8'h00;
   logic [24:0] r;
   int          n_mismatch = 0;
   int          checks = 0;
   // Receive cases: control written, byte sent, bit after data, control read.
   logic [24:0] rows [8] = '{
      {8'h10, 8'h3C, 1'b1, 8'h55}, {8'h10, 8'hC3, 1'b0, 8'h51},
      {8'h30, 8'h81, 1'b0, 8'h70}, {8'h30, 8'h18, 1'b1, 8'h75},
      {8'h90, 8'hA5, 1'b0, 8'hD1}, {8'hB0, 8'h5A, 1'b0, 8'hF0},
      {8'hB0, 8'hE7, 1'b1, 8'hF5}, {8'h00, 8'h66, 1'b1, 8'h40}};

   usc_top #(.OVS(4)) dut (
      .MCLK(MCLK), .RST(RST), .SFR_PAGE(SFR_PAGE), .SFR_ADDR(SFR_ADDR),
      .SFR_WR(SFR_WR), .SFR_WDATA(SFR_WDATA), .SFR_RD(SFR_RD),
      .SFR_RDATA(SFR_RDATA), .BIT_WR(BIT_WR), .BIT_ADDR(BIT_ADDR),
      .BIT_VAL(BIT_VAL), .SAMPLE_TICK(SAMPLE_TICK), .INT_ENABLE(INT_ENABLE),
      .INT_REQ(INT_REQ), .TX_PIN(TX_PIN), .RX_PIN(RX_PIN));

   usc_remote #(.OVS(4)) far (
      .clk(MCLK), .tick(SAMPLE_TICK), .nine(nine), .line_in(TX_PIN),
      .line_out(RX_PIN));

   // Clock, and one tick every second clock so a bit lasts eight clocks.
   always #10 MCLK = ~MCLK;
   always @(posedge MCLK) SAMPLE_TICK <= #1 ~SAMPLE_TICK;

   // Prints the verdict and ends the run.
   task automatic complete_run();
      if (n_mismatch == 0 && checks > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : complete_run

   // Moves to just after the next rising edge.
   task automatic cyc();
      @(posedge MCLK);
      #1;
   endtask : cyc

   // Compares a value and counts the result.
   task automatic chk(input logic [9:0] g, input logic [9:0] e);
      checks++;
      if (g !== e) begin
         n_mismatch++;
         $display("Error at %0t: got %h, expected %h", $time, g, e);
      end
   endtask : chk

   // Byte write, held for one edge, then one idle edge before the next access.
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      SFR_ADDR = a;
      SFR_WDATA = d;
      SFR_WR = 1'b1;
      cyc();
      SFR_WR = 1'b0;
      cyc();
   endtask : wr

   // Byte read; the data is registered so it is compared a cycle later.
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      SFR_ADDR = a;
      SFR_RD = 1'b1;
      cyc();
      SFR_RD = 1'b0;
      cyc();
      chk({2'b00, SFR_RDATA}, {2'b00, e});
   endtask : rd

   // Bit-addressed write of control bit n.
   task automatic bw(input logic [2:0] n, input logic v);
      BIT_ADDR = USC_BIT_BASE + {5'h00, n};
      BIT_VAL = v;
      BIT_WR = 1'b1;
      cyc();
      BIT_WR = 1'b0;
      cyc();
   endtask : bw

   // Waits, bounded, until the far end has taken n frames.
   task automatic wait_tx(input int n);
      int k;
      k = 0;
      while (far.frames < n && k < 400) begin
         cyc();
         k++;
      end
      chk(10'(far.frames), 10'(n));
   endtask : wait_tx

   // Watchdog sized well above the roughly 30 us the sequence needs.
   initial begin
      #100us;
      n_mismatch++;
      complete_run();
   end

   // Main sequence.
   initial begin
      repeat (20) @(posedge MCLK);
      #1 RST = 1'b0;
      cyc();
      chk(10'(TX_PIN), 10'h001);
      rd(USC_CTRL_ADDR, USC_CTRL_RESET);
      SFR_PAGE = 4'h1;
      rd(USC_CTRL_ADDR, 8'h00);
      SFR_PAGE = USC_PAGE;
      rd(8'h9A, 8'h00);
      wr(USC_CTRL_ADDR, 8'hFF);
      rd(USC_CTRL_ADDR, 8'hFF);
      wr(USC_CTRL_ADDR, 8'h00);
      rd(USC_CTRL_ADDR, 8'h40);
      bw(3'h0, 1'b1);
      bw(3'h6, 1'b0);
      INT_ENABLE = 1'b1;
      rd(USC_CTRL_ADDR, 8'h41);
      chk(10'(INT_REQ), 10'h001);
      INT_ENABLE = 1'b0;
      cyc();
      cyc();
      chk(10'(INT_REQ), 10'h000);
      INT_ENABLE = 1'b1;
      bw(3'h0, 1'b0);
      rd(USC_CTRL_ADDR, 8'h40);
      foreach (rows[i]) begin
         r = rows[i];
         nine = r[24];
         wr(USC_CTRL_ADDR, r[24:17]);
         far.send(r[16:9], r[8]);
         repeat (8) cyc();
         rd(USC_CTRL_ADDR, r[7:0]);
         if (r[0]) last = r[16:9];
         rd(USC_DATA_ADDR, last);
         chk(10'(INT_REQ), 10'(r[0]));
      end
      // A frame that arrives while the receive flag is still set is dropped.
      wr(USC_CTRL_ADDR, 8'h11);
      far.send(8'h77, 1'b1);
      repeat (8) cyc();
      rd(USC_CTRL_ADDR, 8'h51);
      rd(USC_DATA_ADDR, last);
      // Nine-bit transmit; the second write lands while busy and is lost.
      nine = 1'b1;
      wr(USC_CTRL_ADDR, 8'h88);
      wr(USC_DATA_ADDR, 8'hA5);
      wr(USC_DATA_ADDR, 8'h5A);
      wait_tx(1);
      chk(far.got, 10'h3A5);
      rd(USC_CTRL_ADDR, 8'hCA);
      repeat (200) cyc();
      chk(10'(far.frames), 10'h001);
      rd(USC_CTRL_ADDR, 8'hCA);
      chk(10'(INT_REQ), 10'h001);
      // Eight-bit transmit: no ninth bit, the stop bit follows bit 7.
      nine = 1'b0;
      wr(USC_CTRL_ADDR, 8'h00);
      wr(USC_DATA_ADDR, 8'h3C);
      wait_tx(2);
      chk(10'(far.got[8:0]), 10'h13C);
      rd(USC_CTRL_ADDR, 8'h42);
      // Reset in mid-run returns the pins, read data and register to idle.
      RST = 1'b1;
      cyc();
      chk({TX_PIN, INT_REQ, SFR_RDATA}, 10'h200);
      RST = 1'b0;
      cyc();
      rd(USC_CTRL_ADDR, USC_CTRL_RESET);
      chk(10'(INT_REQ), 10'h000);
      complete_run();
   end
endmodule : tb_uart_serial_control
`default_nettype wire
